// ==== design/aar_ctrl.sv ====
// aar_ctrl: control/status registers of the extended operating mode.
// assumes a synchronous 8-bit register port from the host interface,
// a symbol tick from the modem and event strobes from the frame engine.
`timescale 1ns/1ps
`default_nettype none
module aar_ctrl
  import aar_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [5:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       sleep_trigger_pin_in,
  input  wire logic       sym_tick_in,
  input  wire logic       high_rate_in,
  input  wire logic [4:0] state_report_in,
  input  wire logic       wake_in,
  input  wire logic       aret_done_in,
  input  wire logic       ack_rx_in,
  input  wire logic       ack_pending_in,
  input  wire logic       no_ack_in,
  input  wire logic       ch_fail_in,
  input  wire logic       rx_end_in,
  input  wire logic       rx_fcs_ok_in,
  input  wire logic       rx_reserved_in,
  input  wire logic       rx_addr_ok_in,
  input  wire logic       rx_ack_req_in,
  input  wire logic [1:0] rx_version_in,
  output logic      [4:0] state_cmd_out,
  output logic            state_cmd_stb_out,
  output logic            tx_begin_out,
  output logic            auto_fcs_out,
  output logic            frame_end_irq_out,
  output logic            address_match_irq_out,
  output logic            ack_send_out,
  output logic      [3:0] frame_retry_limit_out,
  output logic      [2:0] channel_access_retry_limit_out,
  output logic            csma_bypass_out,
  output logic            seed_load_out,
  output logic     [10:0] seed_out
);
  ////////////////////////////////////////////////////////////////////
  // trigger pin synchroniser and rising edge
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic trig_s1_d, trig_s2_d, trig_s3_d;
  logic trig_rise;
  always_comb begin
    trig_s1_d = sleep_trigger_pin_in;
    trig_s2_d = trig_s1_q;
    trig_s3_d = trig_s2_q;
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= trig_s1_d;
      trig_s2_q <= trig_s2_d;
      trig_s3_q <= trig_s3_d;
    end
  end
  assign trig_rise = trig_s2_q & ~trig_s3_q;

  ////////////////////////////////////////////////////////////////////
  // register file
  logic [4:0] cmd_q, cmd_d;
  logic [2:0] result_q, result_d;
  logic [7:0] ctrl1_q, ctrl1_d, xctl1_q, xctl1_d, xctl0_q, xctl0_d;
  logic [7:0] seedl_q, seedl_d, seedh_q, seedh_d;
  logic       cmd_stb_q, cmd_stb_d;
  logic       cmd_valid, cmd_block;
  logic       wr_state;
  assign wr_state = reg_wr_in && (reg_addr_in == OFF_STATE_CTRL);
  // reserved codes are dropped so the transceiver state stays put
  always_comb begin
    case (reg_wdata_in[4:0])
      CMD_NOP, CMD_TX_START, CMD_FORCE_OFF, CMD_FORCE_PLL, CMD_RX_ON,
      CMD_OFF, CMD_PLL_ON, CMD_AACK_ON, CMD_ARET_ON: cmd_valid = 1'b1;
      default: cmd_valid = 1'b0;
    endcase
  end
  // force pll blocked in p_on, sleep, no-clock and transition states
  always_comb begin
    cmd_block = (reg_wdata_in[4:0] == CMD_FORCE_PLL) &&
                (state_report_in == 5'h00 || state_report_in == 5'h0f ||
                 state_report_in >= 5'h1c);
  end
  logic wait_ack_q, wait_ack_d;
  logic ack_go;
  logic rx_accept, rx_endirq, rx_ami;
  always_comb begin
    cmd_d     = cmd_q;
    cmd_stb_d = 1'b0;
    ctrl1_d   = ctrl1_q;
    xctl1_d   = xctl1_q;
    xctl0_d   = xctl0_q;
    seedl_d   = seedl_q;
    seedh_d   = seedh_q;
    result_d  = result_q;
    if (reg_wr_in) begin
      if (wr_state) begin
        if (cmd_valid && !cmd_block) begin
          cmd_d     = reg_wdata_in[4:0];
          cmd_stb_d = (reg_wdata_in[4:0] != CMD_NOP);
        end
      end else if (reg_addr_in == OFF_TRX_CTRL1) begin
        ctrl1_d = reg_wdata_in;
      end else if (reg_addr_in == OFF_EXT_CTRL1) begin
        xctl1_d = reg_wdata_in & MSK_EXT_CTRL1;
      end else if (reg_addr_in == OFF_EXT_CTRL0) begin
        xctl0_d = reg_wdata_in;
      end else if (reg_addr_in == OFF_SEED_LOW) begin
        seedl_d = reg_wdata_in;
      end else if (reg_addr_in == OFF_SEED_HIGH) begin
        seedh_d = reg_wdata_in;
      end
    end
    // result events; later ones take priority
    if (wr_state && cmd_valid && !cmd_block &&
        (reg_wdata_in[4:0] == CMD_AACK_ON || reg_wdata_in[4:0] == CMD_ARET_ON)) begin
      result_d = RES_INVALID;
    end
    if (ch_fail_in) result_d = RES_CH_FAIL;
    if (no_ack_in) result_d = RES_NO_ACK;
    if (ack_rx_in) result_d = ack_pending_in ? RES_PENDING : RES_SUCCESS;
    if (wait_ack_d && !wait_ack_q) result_d = RES_WAIT_ACK;
    if (rx_endirq && !xctl0_q[POS_SLOTTED]) result_d = RES_SUCCESS;
    if (ack_go) result_d = RES_SUCCESS;
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmd_q     <= CMD_NOP;
      cmd_stb_q <= 1'b0;
      result_q  <= RES_SUCCESS;
      ctrl1_q   <= RST_TRX_CTRL1;
      xctl1_q   <= RST_EXT_CTRL1;
      xctl0_q   <= RST_EXT_CTRL0;
      seedl_q   <= RST_SEED_LOW;
      seedh_q   <= RST_SEED_HIGH;
    end else begin
      cmd_q     <= cmd_d;
      cmd_stb_q <= cmd_stb_d;
      result_q  <= result_d; // held between events
      ctrl1_q   <= ctrl1_d;
      xctl1_q   <= xctl1_d;
      xctl0_q   <= xctl0_d;
      seedl_q   <= seedl_d;
      seedh_q   <= seedh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux: state report must be read by host
  always_comb begin
    reg_rdata_out = 8'h00;
    if (reg_addr_in == OFF_STATE_CTRL) begin
      reg_rdata_out = {result_q, cmd_q};
    end else if (reg_addr_in == OFF_STATE_RPT) begin
      reg_rdata_out = {3'h0, state_report_in};
    end else if (reg_addr_in == OFF_TRX_CTRL1) begin
      reg_rdata_out = ctrl1_q;
    end else if (reg_addr_in == OFF_EXT_CTRL1) begin
      reg_rdata_out = xctl1_q;
    end else if (reg_addr_in == OFF_EXT_CTRL0) begin
      reg_rdata_out = xctl0_q;
    end else if (reg_addr_in == OFF_SEED_LOW) begin
      reg_rdata_out = seedl_q;
    end else if (reg_addr_in == OFF_SEED_HIGH) begin
      reg_rdata_out = seedh_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // tx start delay: one symbol tick after the start command
  logic [3:0] tx_cnt_q, tx_cnt_d;
  logic       tx_pend_q, tx_pend_d;
  always_comb begin
    tx_pend_d = tx_pend_q;
    tx_cnt_d  = tx_cnt_q;
    tx_begin_out = 1'b0;
    if (cmd_stb_q && cmd_q == CMD_TX_START) begin
      tx_pend_d = 1'b1;
      tx_cnt_d  = 4'(TX_START_SYM);
    end else if (tx_pend_q && sym_tick_in) begin
      tx_cnt_d = tx_cnt_q - 4'h1;
      if (tx_cnt_q == 4'h1) begin
        tx_pend_d    = 1'b0;
        tx_begin_out = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive frame filtering and ack scheduling
  logic ver_ok;
  logic [3:0] ack_cnt_q, ack_cnt_d;
  logic       ack_pend_q, ack_pend_d;
  always_comb begin
    case (seedh_q[7:6])
      2'h0: ver_ok = (rx_version_in == 2'h0);
      2'h1: ver_ok = (rx_version_in <= 2'h1);
      2'h2: ver_ok = (rx_version_in <= 2'h2);
      default: ver_ok = 1'b1;
    endcase
    // unfiltered reserved frames only need a good fcs and the upload bit
    if (rx_reserved_in && !xctl1_q[POS_RES_FILT]) begin
      rx_accept = rx_fcs_ok_in && xctl1_q[POS_RES_UPLD];
      rx_ami    = 1'b0;
    end else begin
      rx_accept = rx_fcs_ok_in && rx_addr_ok_in && ver_ok &&
                  (!rx_reserved_in || xctl1_q[POS_RES_UPLD]);
      rx_ami    = rx_end_in && rx_addr_ok_in && ver_ok &&
                  (!rx_reserved_in || xctl1_q[POS_RES_UPLD]);
    end
    rx_endirq = rx_end_in && (rx_accept || xctl1_q[POS_PROMISC]);
  end
  assign frame_end_irq_out     = rx_endirq | aret_done_in;
  assign address_match_irq_out = rx_ami;
  // ack only for frames passing filter, also in promiscuous mode
  logic ack_want;
  assign ack_want = rx_end_in && rx_accept && rx_addr_ok_in && rx_ack_req_in &&
                    !seedh_q[POS_ACK_SUPP];
  always_comb begin
    wait_ack_d = wait_ack_q;
    ack_pend_d = ack_pend_q;
    ack_cnt_d  = ack_cnt_q;
    ack_go     = 1'b0;
    if (ack_want) begin
      if (xctl0_q[POS_SLOTTED]) begin
        wait_ack_d = 1'b1;
      end else begin
        ack_pend_d = 1'b1;
        // short delay depends on modulation rate group
        ack_cnt_d = !xctl1_q[POS_SHORT_ACK] ? 4'(ACK_LONG_SYM) :
                    (high_rate_in ? 4'(ACK_SHORT_HI) : 4'(ACK_SHORT_LO));
      end
    end else if (wait_ack_q && trig_rise) begin
      wait_ack_d = 1'b0;
      ack_go     = 1'b1;
    end else if (ack_pend_q && sym_tick_in) begin
      ack_cnt_d = ack_cnt_q - 4'h1;
      if (ack_cnt_q == 4'h1) begin
        ack_pend_d = 1'b0;
        ack_go     = 1'b1;
      end
    end
  end
  assign ack_send_out = ack_go;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_pend_q  <= 1'b0;
      tx_cnt_q   <= 4'h0;
      ack_pend_q <= 1'b0;
      ack_cnt_q  <= 4'h0;
      wait_ack_q <= 1'b0;
    end else begin
      tx_pend_q  <= tx_pend_d;
      tx_cnt_q   <= tx_cnt_d;
      ack_pend_q <= ack_pend_d;
      ack_cnt_q  <= ack_cnt_d;
      wait_ack_q <= wait_ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration outputs and seed load on wake
  assign state_cmd_out     = cmd_q;
  assign state_cmd_stb_out = cmd_stb_q;
  assign auto_fcs_out      = ctrl1_q[POS_AUTO_FCS];
  assign frame_retry_limit_out = xctl0_q[7:4];
  assign channel_access_retry_limit_out = xctl0_q[3:1];
  assign csma_bypass_out = (xctl0_q[3:1] == CSMA_IMMEDIATE);
  assign seed_out      = {seedh_q[2:0], seedl_q};
  assign seed_load_out = wake_in;

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_aret_invalid;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wr_state && reg_wdata_in[4:0] == CMD_ARET_ON && !ch_fail_in && !no_ack_in
       && !ack_rx_in && !rx_end_in && !ack_go) |=> (result_q == RES_INVALID);
  endproperty
  a_aret_invalid: assert property (p_aret_invalid) else $error("no invalid load");
  property p_pending;
    @(posedge sys_clk_in) disable iff (rst_in)
      (ack_rx_in && ack_pending_in && !rx_end_in && !ack_go) |=> (result_q == RES_PENDING);
  endproperty
  a_pending: assert property (p_pending) else $error("pending not reported");
  property p_fcs;
    @(posedge sys_clk_in) disable iff (rst_in) (reg_wr_in && reg_addr_in == OFF_TRX_CTRL1)
      |=> (auto_fcs_out == $past(reg_wdata_in[POS_AUTO_FCS]));
  endproperty
  a_fcs: assert property (p_fcs) else $error("fcs enable wrong");
  property p_bypass;
    @(posedge sys_clk_in) disable iff (rst_in) (reg_wr_in && reg_addr_in == OFF_EXT_CTRL0)
      |=> (csma_bypass_out == ($past(reg_wdata_in[3:1]) == CSMA_IMMEDIATE));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_promisc;
    @(posedge sys_clk_in) disable iff (rst_in)
      (rx_end_in && xctl1_q[1]) |-> frame_end_irq_out;
  endproperty
  a_promisc: assert property (p_promisc) else $error("promisc no irq");
  property p_slot_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wait_ack_q && !trig_rise) |-> !ack_send_out;
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("ack without trigger");
  property p_reserved_cmd;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wr_state && !cmd_valid) |=> (cmd_q == $past(cmd_q) && !cmd_stb_q);
  endproperty
  a_reserved_cmd: assert property (p_reserved_cmd) else $error("reserved cmd acted");
  property p_seed;
    @(posedge sys_clk_in) disable iff (rst_in) (reg_wr_in && reg_addr_in == OFF_SEED_LOW)
      |=> (seed_out[7:0] == $past(reg_wdata_in));
  endproperty
  a_seed: assert property (p_seed) else $error("seed wrong");
endmodule
`default_nettype wire

// ==== design/aar_pkg.sv ====
// aar_pkg: register offsets, field positions, reset values and codes
// for the auto-ack / auto-retry control register bank.
// assumes an 8-bit register port with 6-bit addresses.
package aar_pkg;
  localparam logic [5:0] OFF_STATE_CTRL  = 6'h02;
  localparam logic [5:0] OFF_STATE_RPT   = 6'h01;
  localparam logic [5:0] OFF_TRX_CTRL1   = 6'h04;
  localparam logic [5:0] OFF_EXT_CTRL1   = 6'h17;
  localparam logic [5:0] OFF_EXT_CTRL0   = 6'h2c;
  localparam logic [5:0] OFF_SEED_LOW    = 6'h2d;
  localparam logic [5:0] OFF_SEED_HIGH   = 6'h2e;
  // reset values
  localparam logic [7:0] RST_TRX_CTRL1   = 8'h20;
  localparam logic [7:0] RST_EXT_CTRL1   = 8'h00;
  localparam logic [7:0] RST_EXT_CTRL0   = 8'h38;
  localparam logic [7:0] RST_SEED_LOW    = 8'hea;
  localparam logic [7:0] RST_SEED_HIGH   = 8'h42;
  // writable masks (reserved bits read zero)
  localparam logic [7:0] MSK_EXT_CTRL1   = 8'h76;
  // field positions
  localparam int POS_AUTO_FCS   = 5;
  localparam int POS_RES_FILT   = 5;
  localparam int POS_RES_UPLD   = 4;
  localparam int POS_SHORT_ACK  = 2;
  localparam int POS_PROMISC    = 1;
  localparam int POS_SLOTTED    = 0;
  localparam int POS_ACK_SUPP   = 4;
  // state commands
  localparam logic [4:0] CMD_NOP        = 5'h00;
  localparam logic [4:0] CMD_TX_START   = 5'h02;
  localparam logic [4:0] CMD_FORCE_OFF  = 5'h03;
  localparam logic [4:0] CMD_FORCE_PLL  = 5'h04;
  localparam logic [4:0] CMD_RX_ON      = 5'h06;
  localparam logic [4:0] CMD_OFF        = 5'h08;
  localparam logic [4:0] CMD_PLL_ON     = 5'h09;
  localparam logic [4:0] CMD_AACK_ON    = 5'h16;
  localparam logic [4:0] CMD_ARET_ON    = 5'h19;
  // transaction results
  localparam logic [2:0] RES_SUCCESS    = 3'h0;
  localparam logic [2:0] RES_PENDING    = 3'h1;
  localparam logic [2:0] RES_WAIT_ACK   = 3'h2;
  localparam logic [2:0] RES_CH_FAIL    = 3'h3;
  localparam logic [2:0] RES_NO_ACK     = 3'h5;
  localparam logic [2:0] RES_INVALID    = 3'h7;
  // special retry value and symbol delays
  localparam logic [2:0] CSMA_IMMEDIATE = 3'h7;
  localparam int TX_START_SYM   = 1;
  localparam int ACK_LONG_SYM   = 12;
  localparam int ACK_SHORT_LO   = 2;
  localparam int ACK_SHORT_HI   = 3;
endpackage

// ==== tb/aar_host_model.sv ====
// aar_host_model: host side of the register port and the trigger pin.
// assumes one clock shared with the block and read data settled by mid-cycle.
`timescale 1ns/1ps
`default_nettype none
module aar_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [5:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            trig_out
);
  ////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 6'h3f;
    wdata_out = 8'h00;
    trig_out = 1'b0;
  end
  // one write strobe; the filter bit never goes out without upload
  task automatic write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= (a == 6'h17 && d[5]) ? (d | 8'h10) : d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d; // released bus must not look like the last value
  endtask
  // read data is taken mid-cycle while the address stands
  task automatic read(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(negedge clk_in);
    d = rdata_in;
    @(posedge clk_in);
    rd_out <= 1'b0;
  endtask
  // trigger pulse on a slot boundary, long enough for the synchroniser
  task automatic pulse_trig();
    @(posedge clk_in);
    trig_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    trig_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// tb: drives the control bank through the host model and a frame-engine stand-in.
// assumes one 125 MHz clock; all stimulus moves on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import aar_pkg::*;
  logic        clk, rst, rd, wr, trig, sym, hr, wake, adone, ackr, ackp, noack, chf;
  logic        rxe, fcs, rsv, aok, req, cstb, txb, afcs, fei, address_match_irq, acks, csb, sld;
  logic [1:0]  ver;
  logic [4:0]  srep, cmd;
  logic [5:0]  addr;
  logic [7:0]  wdat, rdat, v;
  logic [3:0]  frl;
  logic [2:0]  carl;
  logic [10:0] seed;
  int          error_cnt, check_count, tick_n, ack_at;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  aar_ctrl DUT (.sys_clk_in(clk), .rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_rdata_out(rdat),
    .sleep_trigger_pin_in(trig), .sym_tick_in(sym), .high_rate_in(hr),
    .state_report_in(srep), .wake_in(wake), .aret_done_in(adone), .ack_rx_in(ackr),
    .ack_pending_in(ackp), .no_ack_in(noack), .ch_fail_in(chf), .rx_end_in(rxe),
    .rx_fcs_ok_in(fcs), .rx_reserved_in(rsv), .rx_addr_ok_in(aok), .rx_ack_req_in(req),
    .rx_version_in(ver), .state_cmd_out(cmd), .state_cmd_stb_out(cstb),
    .tx_begin_out(txb), .auto_fcs_out(afcs), .frame_end_irq_out(fei),
    .address_match_irq_out(address_match_irq), .ack_send_out(acks), .frame_retry_limit_out(frl),
    .channel_access_retry_limit_out(carl), .csma_bypass_out(csb),
    .seed_load_out(sld), .seed_out(seed));
  aar_host_model host (.clk_in(clk), .rdata_in(rdat), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdat), .trig_out(trig));
  // remember on which symbol tick the ack went out
  always @(negedge clk) if (acks === 1'b1) ack_at = tick_n;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    host.read(a, v);
    chk(n, {3'h0, e}, {3'h0, v & m});
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle pulses from the frame engine: no_ack, ack, ch_fail, done, wake
  task automatic evt(input logic [4:0] m);
    @(posedge clk);
    {noack, ackr, chf, adone, wake} <= m;
    @(negedge clk);
    chk("frame end", {10'h0, m[1]}, {10'h0, fei});
    chk("seed load", {10'h0, m[0]}, {10'h0, sld});
    @(posedge clk);
    {noack, ackr, chf, adone, wake} <= 5'h0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      sym <= 1'b1;
      tick_n++;
      @(posedge clk);
      sym <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // one received frame with matching address and ack request
  task automatic t_rx(input logic [7:0] c17, input logic [7:0] c2e, input logic h,
                      input logic f, input logic r, input logic [1:0] vn,
                      input logic efe, input int eack);
    host.write(OFF_EXT_CTRL1, c17);
    host.write(OFF_SEED_HIGH, c2e);
    hr <= h;
    @(posedge clk);
    {rxe, fcs, rsv, aok, req, ver} <= {1'b1, f, r, 1'b1, 1'b1, vn};
    ack_at = -1;
    tick_n = 0;
    @(negedge clk);
    chk("frame end", {10'h0, efe}, {10'h0, fei});
    if (c17[5]) chk("addr irq", 11'h1, {10'h0, address_match_irq});
    @(posedge clk);
    rxe <= 1'b0;
    ticks(14);
    chk("ack tick", eack[10:0], ack_at[10:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [5:0] oa [6] = '{6'h02, 6'h04, 6'h17, 6'h2c, 6'h2d, 6'h2e};
    logic [7:0] ev [6] = '{8'h00, 8'h20, 8'h00, 8'h38, 8'hea, 8'h42};
    for (int i = 0; i < 6; i++) rchk("reset", oa[i], 8'hff, ev[i]);
    chk("seed", 11'h2ea, seed);
    chk("frame retries", 11'h3, {7'h0, frl});
    chk("csma retries", 11'h4, {8'h0, carl});
    chk("auto fcs", 11'h1, {10'h0, afcs});
    host.write(OFF_TRX_CTRL1, 8'h00);
    host.write(OFF_EXT_CTRL1, 8'hff);
    rchk("ctrl1 mask", OFF_EXT_CTRL1, 8'hff, 8'h76);
    chk("auto fcs off", 11'h0, {10'h0, afcs});
    host.write(OFF_EXT_CTRL0, 8'h7e);
    @(negedge clk);
    chk("frame retries", 11'h7, {7'h0, frl});
    chk("csma bypass", 11'h1, {10'h0, csb});
    host.write(OFF_EXT_CTRL0, 8'h38);
    host.write(OFF_SEED_LOW, 8'h5a);
    host.write(OFF_SEED_HIGH, 8'h45);
    evt(5'h01);
    chk("seed", 11'h55a, seed);
  endtask
  task automatic t_cmd();
    logic [4:0] cl [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
                            5'h09, 5'h16, 5'h19};
    logic es [11] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 11; i++) begin
      host.write(OFF_STATE_CTRL, {3'h0, cl[i]});
      @(negedge clk);
      chk("cmd strobe", {10'h0, es[i]}, {10'h0, cstb});
      if (es[i]) chk("cmd", {6'h0, cl[i]}, {6'h0, cmd});
    end
    host.write(OFF_STATE_CTRL, {3'h0, CMD_TX_START});
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("tx early", 11'h0, {10'h0, txb});
    @(posedge clk);
    sym <= 1'b1;
    @(negedge clk);
    chk("tx begin", 11'h1, {10'h0, txb});
    @(posedge clk);
    sym <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      srep <= i ? 5'h1c : 5'h0f;
      host.write(OFF_STATE_CTRL, {3'h0, CMD_FORCE_PLL});
      @(negedge clk);
      chk("force pll", 11'h0, {10'h0, cstb});
      rchk("state report", OFF_STATE_RPT, 8'h1f, {3'h0, srep});
    end
    @(posedge clk);
    srep <= 5'h08;
  endtask
  task automatic t_aret();
    host.write(OFF_STATE_CTRL, {3'h0, CMD_ARET_ON});
    rchk("result", OFF_STATE_CTRL, 8'he0, 8'he0);
    evt(5'h10);
    rchk("result", OFF_STATE_CTRL, 8'he0, 8'ha0);
    repeat (20) @(posedge clk);
    rchk("result", OFF_STATE_CTRL, 8'he0, 8'ha0);
    ackp <= 1'b1;
    evt(5'h08);
    rchk("result", OFF_STATE_CTRL, 8'he0, 8'h20);
    ackp <= 1'b0;
    evt(5'h08);
    rchk("result", OFF_STATE_CTRL, 8'he0, 8'h00);
    evt(5'h04);
    rchk("result", OFF_STATE_CTRL, 8'he0, 8'h60);
    evt(5'h02);
    host.write(OFF_STATE_CTRL, {3'h0, CMD_AACK_ON});
    rchk("result", OFF_STATE_CTRL, 8'he0, 8'he0);
  endtask
  task automatic t_ack();
    t_rx(8'h00, 8'h42, 1'b0, 1'b1, 1'b0, 2'h1, 1'b1, 12);
    t_rx(8'h04, 8'h42, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1, 2);
    t_rx(8'h04, 8'h42, 1'b1, 1'b1, 1'b0, 2'h0, 1'b1, 3);
    t_rx(8'h04, 8'h52, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1, -1);
    t_rx(8'h04, 8'h02, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0, -1);
    t_rx(8'h04, 8'h82, 1'b0, 1'b1, 1'b0, 2'h2, 1'b1, 2);
    t_rx(8'h04, 8'hc2, 1'b0, 1'b1, 1'b0, 2'h3, 1'b1, 2);
    t_rx(8'h34, 8'h42, 1'b0, 1'b1, 1'b1, 2'h0, 1'b1, 2);
    t_rx(8'h14, 8'h42, 1'b0, 1'b1, 1'b1, 2'h0, 1'b1, 2);
    t_rx(8'h06, 8'h42, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1, 2);
    t_rx(8'h06, 8'h42, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1, -1);
    t_rx(8'h04, 8'h42, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, -1);
    // slotted: no ack on the ticks alone, only after the trigger edge
    host.write(OFF_EXT_CTRL0, 8'h39);
    t_rx(8'h00, 8'h42, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1, -1);
    rchk("wait result", OFF_STATE_CTRL, 8'he0, 8'h40);
    host.pulse_trig();
    repeat (6) @(posedge clk);
    chk("slotted ack", 11'd14, ack_at[10:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {sym, hr, wake, adone, ackr, ackp, noack, chf, rxe, fcs, rsv, aok, req} = '0;
    ver = 2'h0;
    srep = 5'h08;
    rst = 1'b1;
    error_cnt = 0;
    check_count = 0;
    tick_n = 0;
    ack_at = -1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_cmd();
    t_aret();
    t_ack();
    conclude();
  end
  // a hang is far longer than the thousand or so cycles of the sequence
  initial begin
    #(8 * 40000);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
